// *** rtl/nv_access_pkg.sv ***
// Constants and carrier types for the information memory and data EEPROM write control.
// Assumes a 100 MHz system clock and an external-data load and store path from the CPU core.
package nv_access_pkg;

    localparam int          clk_period_ns          = 10;
    localparam int          write_time_us          = 600;
    localparam int          timeout_1_us           = 1600;
    localparam int          timeout_2_us           = 3100;
    localparam int          timeout_3_us           = 12500;
    localparam int          write_cycles           = write_time_us * 1000 / clk_period_ns;
    localparam int          timeout_1_cycles       = timeout_1_us * 1000 / clk_period_ns;
    localparam int          timeout_2_cycles       = timeout_2_us * 1000 / clk_period_ns;
    localparam int          timeout_3_cycles       = timeout_3_us * 1000 / clk_period_ns;

    localparam logic [7:0]  key_register_offset    = 8'hc9;
    localparam logic [7:0]  aux_register_offset    = 8'hf7;
    localparam logic [7:0]  aux_reset              = 8'h06;

    localparam logic [7:0]  key_flash_one_byte     = 8'h47;
    localparam logic [7:0]  key_flash_two_byte     = 8'h74;
    localparam logic [7:0]  key_info               = 8'ha1;
    localparam logic [7:0]  key_eeprom             = 8'he2;

    localparam int          flash_we_bit           = 7;
    localparam int          timeout_flag_bit       = 6;
    localparam int          eeprom_we_bit          = 5;
    localparam int          info_we_bit            = 4;
    localparam int          timeout_sel_lsb        = 1;
    localparam int          watchdog_ctrl_lsb      = 6;

    localparam logic [15:0] info_base              = 16'he500;
    localparam logic [15:0] info_last              = 16'he53f;
    localparam logic [15:0] info_boot_first        = 16'he520;
    localparam logic [15:0] eeprom_base            = 16'hee00;
    localparam logic [15:0] eeprom_last            = 16'heefe;

    typedef enum logic [1:0] {
        st_idle    = 2'b00,
        st_program = 2'b01,
        st_done    = 2'b11
    } write_state_type;

    typedef struct packed {
        logic        sfr_write;
        logic        sfr_read;
        logic [7:0]  sfr_addr;
        logic [7:0]  sfr_wdata;
        logic        xdata_write;
        logic        xdata_read;
        logic [15:0] xdata_addr;
        logic [7:0]  xdata_wdata;
    } cpu_access_type;

endpackage : nv_access_pkg

// *** rtl/info_eeprom_write_control.sv ***
// Write key, timeout and storage for the information memory and the data EEPROM.
// Assumes CPU strobes are one-cycle pulses synchronous to clk; boot_mode is a level.
// Behaviour
// - Sixty-four information bytes sit at E500h to E53Fh in two sectors.
// - Information writes need boot mode, boot sector address and the info enable flag.
// - An enabled information store programs the byte and stalls the CPU about 0.6 ms.
// - Peripherals and interrupts run on while the CPU is stalled.
// - Information reads by load at E500h to E53Fh complete without wait.
// - Key A1h sets the info enable flag; other values clear it.
// - Keys 47h or 74h set the flash enable flag, one or two bytes.
// - Key E2h sets the EEPROM enable flag; other values clear it.
// - Key register bit 4 reads the info enable flag, reset zero.
// - Key register bit 5 reads the EEPROM enable flag, reset zero.
// - Timeout flag on bit 6 sets on timeout, clears when all three enable flags are clear.
// - Timeout select 00 off, else 1.6, 3.1, 12.5 ms; expiry abandons the write.
// - One timeout mechanism serves EEPROM and information writes.
// - Watchdog control bits 7:6: 0x off, 10 fast and slow, 11 always.
// - 128 EEPROM bytes at even addresses EE00h to EEFEh; odd addresses invalid.
// - EEPROM bytes write without erase; each enabled store stalls about 0.6 ms.
// - EEPROM reads by load at EE00h to EEFEh.
// - Key register bit 7 reads the flash enable flag, reset zero.
`timescale 1ns/1ns
module info_eeprom_write_control #(
    parameter int write_count     = nv_access_pkg::write_cycles,
    parameter int timeout_count_1 = nv_access_pkg::timeout_1_cycles,
    parameter int timeout_count_2 = nv_access_pkg::timeout_2_cycles,
    parameter int timeout_count_3 = nv_access_pkg::timeout_3_cycles,
    parameter int program_fail    = 0
) (
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire logic                         boot_mode,
    input  wire nv_access_pkg::cpu_access_type cpu,
    output logic [7:0]                        sfr_rdata,
    output logic [7:0]                        xdata_rdata,
    output logic                              xdata_hit,
    output logic                              cpu_wait,
    output logic                              flash_two_byte,
    output logic [1:0]                        watchdog_reset_control,
    output logic                              timeout_event
);

    typedef struct packed {
        nv_access_pkg::write_state_type state;
        logic        flash_write_enable_flag;
        logic        flash_two_byte;
        logic        eeprom_write_enable_flag;
        logic        info_write_enable_flag;
        logic        write_timeout_flag;
        logic [7:0]  aux;
        logic [23:0] program_count;
        logic [23:0] timeout_count;
        logic        target_eeprom;
        logic [6:0]  target_index;
        logic [7:0]  target_data;
        logic [7:0]  sfr_rdata;
        logic [7:0]  xdata_rdata;
        logic        xdata_hit;
        logic        cpu_wait;
        logic        timeout_event;
    } state_type;

    state_type   r;
    state_type   next_r;
    logic [7:0]  info_mem [64];
    logic [7:0]  eeprom_mem [128];
    logic        commit;
    logic [23:0] timeout_limit;
    logic        is_info;
    logic        is_eeprom;
    logic        info_store_ok;
    logic        eeprom_store_ok;

    always_comb begin
        is_info   = cpu.xdata_addr >= nv_access_pkg::info_base && cpu.xdata_addr <= nv_access_pkg::info_last;
        is_eeprom = cpu.xdata_addr >= nv_access_pkg::eeprom_base && cpu.xdata_addr <= nv_access_pkg::eeprom_last
                    && !cpu.xdata_addr[0];
        info_store_ok = is_info && boot_mode && r.info_write_enable_flag
                        && cpu.xdata_addr >= nv_access_pkg::info_boot_first;
        eeprom_store_ok = is_eeprom && r.eeprom_write_enable_flag;
        case (r.aux[nv_access_pkg::timeout_sel_lsb +: 2])
            2'b01:   timeout_limit = 24'(timeout_count_1);
            2'b10:   timeout_limit = 24'(timeout_count_2);
            2'b11:   timeout_limit = 24'(timeout_count_3);
            default: timeout_limit = 24'h000000;
        endcase
    end

    always_comb begin
        next_r = r;
        commit = 1'b0;
        next_r.timeout_event = 1'b0;
        if (cpu.sfr_write && cpu.sfr_addr == nv_access_pkg::key_register_offset) begin
            next_r.info_write_enable_flag   = cpu.sfr_wdata == nv_access_pkg::key_info;
            next_r.eeprom_write_enable_flag = cpu.sfr_wdata == nv_access_pkg::key_eeprom;
            next_r.flash_write_enable_flag  = cpu.sfr_wdata == nv_access_pkg::key_flash_one_byte
                                              || cpu.sfr_wdata == nv_access_pkg::key_flash_two_byte;
            next_r.flash_two_byte = cpu.sfr_wdata == nv_access_pkg::key_flash_two_byte;
        end else if (cpu.sfr_write && cpu.sfr_addr == nv_access_pkg::aux_register_offset) begin
            next_r.aux = cpu.sfr_wdata;
        end
        if (cpu.sfr_read) begin
            if (cpu.sfr_addr == nv_access_pkg::key_register_offset) begin
                next_r.sfr_rdata = {r.flash_write_enable_flag, r.write_timeout_flag, r.eeprom_write_enable_flag,
                                    r.info_write_enable_flag, 4'h0};
            end else if (cpu.sfr_addr == nv_access_pkg::aux_register_offset) begin
                next_r.sfr_rdata = r.aux;
            end else begin
                next_r.sfr_rdata = 8'h00;
            end
        end
        next_r.xdata_hit = 1'b0;
        if (cpu.xdata_read && is_info) begin
            next_r.xdata_rdata = info_mem[cpu.xdata_addr[5:0]];
            next_r.xdata_hit   = 1'b1;
        end else if (cpu.xdata_read && is_eeprom) begin
            next_r.xdata_rdata = eeprom_mem[cpu.xdata_addr[7:1]];
            next_r.xdata_hit   = 1'b1;
        end
        case (r.state)
            nv_access_pkg::st_idle: begin
                if (cpu.xdata_write && (info_store_ok || eeprom_store_ok)) begin
                    next_r.state         = nv_access_pkg::st_program;
                    next_r.target_eeprom = eeprom_store_ok;
                    next_r.target_index  = eeprom_store_ok ? cpu.xdata_addr[7:1] : {1'b0, cpu.xdata_addr[5:0]};
                    next_r.target_data   = cpu.xdata_wdata;
                    next_r.program_count = 24'h000000;
                    next_r.timeout_count = 24'h000000;
                    next_r.cpu_wait      = 1'b1;
                end
            end
            nv_access_pkg::st_program: begin
                next_r.program_count = r.program_count + 24'h000001;
                next_r.timeout_count = r.timeout_count + 24'h000001;
                if (program_fail == 0 && r.program_count + 24'h000001 >= 24'(write_count)) begin
                    commit          = 1'b1;
                    next_r.state    = nv_access_pkg::st_done;
                    next_r.cpu_wait = 1'b0;
                end else if (timeout_limit != 24'h000000 && r.timeout_count + 24'h000001 >= timeout_limit) begin
                    next_r.write_timeout_flag = 1'b1;
                    next_r.timeout_event      = 1'b1;
                    next_r.state              = nv_access_pkg::st_done;
                    next_r.cpu_wait           = 1'b0;
                end
            end
            nv_access_pkg::st_done: begin
                next_r.state = nv_access_pkg::st_idle;
            end
            default: begin
                next_r.state = nv_access_pkg::st_idle;
            end
        endcase
        if (!next_r.flash_write_enable_flag && !next_r.eeprom_write_enable_flag && !next_r.info_write_enable_flag
            && !next_r.timeout_event) begin
            next_r.write_timeout_flag = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r       <= '0;
            r.aux   <= nv_access_pkg::aux_reset;
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge clk) begin
        if (commit && r.target_eeprom) begin
            eeprom_mem[r.target_index] <= r.target_data;
        end
        if (commit && !r.target_eeprom) begin
            info_mem[r.target_index[5:0]] <= r.target_data;
        end
    end

    always_comb begin
        sfr_rdata              = r.sfr_rdata;
        xdata_rdata            = r.xdata_rdata;
        xdata_hit              = r.xdata_hit;
        cpu_wait               = r.cpu_wait;
        flash_two_byte         = r.flash_two_byte;
        watchdog_reset_control = r.aux[nv_access_pkg::watchdog_ctrl_lsb +: 2];
        timeout_event          = r.timeout_event;
    end

endmodule : info_eeprom_write_control

// *** test/nv_access_chk.sv ***
// Port assertions for the write control block.
// Assumes it is bound to info_eeprom_write_control.
`timescale 1ns/1ns
module nv_access_chk #(parameter int write_count = 20) (
    input wire logic                          clk,
    input wire logic                          resetn,
    input wire logic                          boot_mode,
    input wire nv_access_pkg::cpu_access_type cpu,
    input wire logic [7:0]                    sfr_rdata,
    input wire logic [7:0]                    xdata_rdata,
    input wire logic                          xdata_hit,
    input wire logic                          cpu_wait,
    input wire logic                          flash_two_byte,
    input wire logic [1:0]                    watchdog_reset_control,
    input wire logic                          timeout_event
);
    logic [7:0] key;
    int         wcnt;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            key  <= 8'h00;
            wcnt <= 0;
        end else begin
            key  <= (cpu.sfr_write && cpu.sfr_addr == 8'hc9) ? cpu.sfr_wdata : key;
            wcnt <= cpu_wait ? wcnt + 1 : 0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wait_bound_a: assert property (cpu_wait |-> wcnt < write_count) else $error("stall too long");
    key_flags_a: assert property (cpu.sfr_read && cpu.sfr_addr == 8'hc9 |=> sfr_rdata == {$past(key) == 8'h47
        || $past(key) == 8'h74, sfr_rdata[6], $past(key) == 8'he2, $past(key) == 8'ha1, 4'h0}) else $error("bad flags");
    one_flag_a: assert property ($onehot0({sfr_rdata[7], sfr_rdata[5:4]})) else $error("two flags set");
    refused_a: assert property (cpu.xdata_write && !cpu_wait && !(key == 8'he2 || key == 8'ha1 && boot_mode)
        |=> !cpu_wait) else $error("refused store stalled");
    odd_ee_a: assert property (cpu.xdata_write && cpu.xdata_addr[15:8] == 8'hee && cpu.xdata_addr[0]
        && !cpu_wait |=> !cpu_wait) else $error("odd store stalled");
    ee_start_a: assert property (cpu.xdata_write && !cpu_wait && !$past(cpu_wait) && key == 8'he2
        && cpu.xdata_addr[15:8] == 8'hee && !cpu.xdata_addr[0] |=> cpu_wait) else $error("store not started");
    read_hit_a: assert property (cpu.xdata_read && (cpu.xdata_addr inside {[16'he500:16'he53f]}
        || cpu.xdata_addr[15:8] == 8'hee && !cpu.xdata_addr[0]) |=> xdata_hit && !cpu_wait) else $error("no hit");
    two_byte_a: assert property (cpu.sfr_write && cpu.sfr_addr == 8'hc9
        |=> flash_two_byte == ($past(cpu.sfr_wdata) == 8'h74)) else $error("bad two byte mode");
    wdog_ctrl_a: assert property (cpu.sfr_write && cpu.sfr_addr == 8'hf7
        |=> watchdog_reset_control == $past(cpu.sfr_wdata[7:6])) else $error("bad watchdog field");
    timeout_end_a: assert property (timeout_event |=> !timeout_event && !cpu_wait) else $error("timeout");
endmodule : nv_access_chk
bind info_eeprom_write_control nv_access_chk #(.write_count(write_count)) chk (.clk(clk), .resetn(resetn),
    .boot_mode(boot_mode), .cpu(cpu), .sfr_rdata(sfr_rdata), .xdata_rdata(xdata_rdata), .xdata_hit(xdata_hit),
    .cpu_wait(cpu_wait), .flash_two_byte(flash_two_byte), .watchdog_reset_control(watchdog_reset_control),
    .timeout_event(timeout_event));

// *** test/cpu_core_model.sv ***
// Model of the CPU core issuing register and external-data accesses.
// Assumes one-cycle strobes taken at the rising edge of clk.
`timescale 1ns/1ns
module cpu_core_model (
    input wire logic                     clk,
    input wire logic                     cpu_wait,
    output nv_access_pkg::cpu_access_type cpu
);
    initial cpu = '0;
    task go(input logic [3:0] s, input logic [15:0] a, input logic [7:0] d);
        nv_access_pkg::cpu_access_type c;
        c = '{s[3], s[2], a[7:0], d, s[1], s[0], a, d};
        @(posedge clk);
        cpu <= c;
        @(posedge clk);
        c             = ~c;
        c.sfr_write   = 1'b0;
        c.sfr_read    = 1'b0;
        c.xdata_write = 1'b0;
        c.xdata_read  = 1'b0;
        cpu <= c;
    endtask : go
    task x_wr(input logic [15:0] a, input logic [7:0] d, output int n);
        go(4'b0010, a, d);
        n = 0;
        repeat (60) begin
            @(posedge clk);
            if (cpu_wait) n++;
            else if (n > 0) break;
        end
        @(posedge clk);
    endtask : x_wr
endmodule : cpu_core_model

// *** test/info_eeprom_write_control_test.sv ***
// Self-checking bench for the information memory and EEPROM write control.
// Assumes the CPU model drives every access; expected read data is queued.
`timescale 1ns/1ns
module info_eeprom_write_control_test;
    logic clk = 0, resetn = 0, boot_mode = 0, rd1 = 0, xdata_hit, cpu_wait, flash_two_byte, timeout_event;
    logic [7:0] sfr_rdata, xdata_rdata, d, q[$];
    logic [1:0] watchdog_reset_control;
    logic [31:0] seed = 32'h39a8;
    logic [15:0] kt[5] = '{16'ha110, 16'he220, 16'h4780, 16'h7480, 16'h5a00};
    logic [15:0] ea[3] = '{16'hee00, 16'hee02, 16'heefe};
    nv_access_pkg::cpu_access_type cpu;
    int fails = 0, n_tests = 0, n_to = 0, n;
    info_eeprom_write_control #(.write_count(20), .timeout_count_1(10), .timeout_count_2(40),
        .timeout_count_3(50)) dut (.clk(clk), .resetn(resetn), .boot_mode(boot_mode), .cpu(cpu),
        .sfr_rdata(sfr_rdata), .xdata_rdata(xdata_rdata), .xdata_hit(xdata_hit), .cpu_wait(cpu_wait),
        .flash_two_byte(flash_two_byte), .watchdog_reset_control(watchdog_reset_control),
        .timeout_event(timeout_event));
    cpu_core_model cpu_m (.clk(clk), .cpu_wait(cpu_wait), .cpu(cpu));
    initial forever #5 clk = ~clk;
    task check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task test_done;
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task rd(input logic [15:0] a, input logic [7:0] e, input logic x);
        q.push_back(e);
        cpu_m.go(x ? 4'b0001 : 4'b0100, a, 8'h00);
    endtask : rd
    task xw(input logic [15:0] a, input logic [7:0] v, input int e);
        cpu_m.x_wr(a, v, n);
        check("wait cycles", e[7:0], n[7:0]);
    endtask : xw
    always @(posedge clk) begin
        rd1 <= cpu.sfr_read;
        if (timeout_event === 1'b1) n_to++;
        if (rd1) check("sfr_rdata", q.pop_front(), sfr_rdata);
        if (xdata_hit === 1'b1) check("xdata_rdata", q.pop_front(), xdata_rdata);
    end
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1;
        rd(16'h00c9, 8'h00, 0);
        rd(16'h00f7, 8'h06, 0);
        foreach (kt[i]) begin
            cpu_m.go(4'b1000, 16'h00c9, kt[i][15:8]);
            rd(16'h00c9, kt[i][7:0], 0);
            check("flash_two_byte", {7'h0, kt[i][15:8] == 8'h74}, {7'h0, flash_two_byte});
        end
        cpu_m.go(4'b1000, 16'h00f7, 8'hc6);
        rd(16'h00f7, 8'hc6, 0);
        check("watchdog_reset_control", 8'h03, {6'h0, watchdog_reset_control});
        $display("register test done");
        cpu_m.go(4'b1000, 16'h00f7, 8'h06);
        rd(16'h00f7, 8'h06, 0);
        check("watchdog_reset_control", 8'h00, {6'h0, watchdog_reset_control});
        foreach (ea[i]) begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            d = seed[7:0];
            cpu_m.go(4'b1000, 16'h00c9, 8'he2);
            xw(ea[i], d, 20);
            cpu_m.go(4'b1000, 16'h00c9, 8'h00);
            rd(ea[i], d, 1);
        end
        cpu_m.go(4'b1000, 16'h00c9, 8'he2);
        xw(16'heeff, ~d, 0);
        cpu_m.go(4'b1000, 16'h00c9, 8'h00);
        xw(16'heefe, ~d, 0);
        rd(16'heefe, d, 1);
        $display("eeprom test done");
        boot_mode <= 1;
        cpu_m.go(4'b1000, 16'h00c9, 8'ha1);
        xw(16'he530, d, 20);
        xw(16'he530, d, 20);
        xw(16'he51f, d, 0);
        boot_mode <= 0;
        xw(16'he53f, d, 0);
        cpu_m.go(4'b1000, 16'h00c9, 8'h00);
        rd(16'he530, d, 1);
        $display("info test done");
        for (int s = 0; s < 4; s++) begin
            cpu_m.go(4'b1000, 16'h00f7, 8'(s * 2));
            cpu_m.go(4'b1000, 16'h00c9, 8'he2);
            xw(16'hee10, d, s == 1 ? 10 : 20);
            rd(16'h00c9, s == 1 ? 8'h60 : 8'h20, 0);
            cpu_m.go(4'b1000, 16'h00c9, 8'h00);
        end
        rd(16'h00c9, 8'h00, 0);
        repeat (3) @(posedge clk);
        check("timeout events", 8'h01, n_to[7:0]);
        $display("timeout test done");
        test_done();
    end
    initial begin
        #200000;
        fails++;
        test_done();
    end
endmodule : info_eeprom_write_control_test
